// ---- include/dcr_pkg.sv ----
`default_nettype none
package dcr_pkg;
   // register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] DISPLAY_CONTROL_OFS = 8'h03;
   localparam logic [7:0] STATUS_OFS          = 8'h05;
   localparam int CTRL_W = 11;
   localparam logic [10:0] CTRL_RESET = 11'h000;
   // field positions of display_control
   localparam int TIMING_GEN_RUN_BIT    = 0;
   localparam int OUTPUT_RUN_BIT        = 1;
   localparam int LINE_SYNC_SELECT_BIT  = 2;
   localparam int FRAME_LOCK_SELECT_BIT = 3;
   localparam int FRAME_SYNC_IN_EN_BIT  = 4;
   localparam int OVL_ONE_EN_BIT        = 5;
   localparam int OVL_TWO_EN_BIT        = 6;
   localparam int FORCE_BACKDROP_BIT    = 7;
   localparam int BACKDROP_SEL_LSB      = 8;
   localparam int BACKDROP_SEL_W        = 3;
   // pixel layout
   localparam int PIX_W = 24;
   localparam int PAL_N = 8;
   // default palette, one 24-bit rgb word per select code
   localparam logic [PAL_N*PIX_W-1:0] PALETTE_DEFAULT = {
      24'hFFFFFF, 24'hFFFF00, 24'hFF00FF, 24'hFF0000,
      24'h00FFFF, 24'h00FF00, 24'h0000FF, 24'h000000};
   // synchronisation modes, {line, frame} select pair
   typedef enum logic [3:0] {
      DCR_CLOCK_SYNC = 4'h1,
      DCR_LINE_SYNC  = 4'h2,
      DCR_FRAME_SYNC = 4'h4,
      DCR_FREE_RUN   = 4'h8
   } dcr_sync_mode_t;
endpackage
`default_nettype wire

// ---- include/dcr_ctrl_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// decoded control fields from register bank to output path
interface dcr_ctrl_if;
   import dcr_pkg::*;
   logic           timingRun;   // timing generator runs
   logic           outputRun;   // pins released
   logic           ovlOneEn;    // overlay region one on
   logic           ovlTwoEn;    // overlay region two on
   logic           forceBack;   // backdrop forced
   logic [2:0]     backSel;     // backdrop colour code
   modport bank (output timingRun, outputRun, ovlOneEn, ovlTwoEn, forceBack, backSel);
   modport path (input timingRun, outputRun, ovlOneEn, ovlTwoEn, forceBack, backSel);
endinterface
`default_nettype wire

// ---- logic/dcr_sync_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
// sync mode decode and frame sync input qualifier
module dcr_sync_decode
   import dcr_pkg::*;
(
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   // control fields
   input  wire logic          lineSel,
   input  wire logic          frameSel,
   input  wire logic          fsyncEn,
   // synchronised frame sync pin, active low
   input  wire logic          fsyncSyncN,
   // results
   output dcr_pkg::dcr_sync_mode_t syncMode,
   output logic               frameSyncPulse
);
   logic fsyncPrevN_q;   // last pin level
   logic fsyncPrevN_d;
   logic qualified;      // pin allowed to act

   // mode table from the two select bits
   always_comb
   begin
      case ({lineSel, frameSel})
         2'b11:   syncMode = DCR_FREE_RUN;
         2'b01:   syncMode = DCR_FRAME_SYNC;
         2'b10:   syncMode = DCR_LINE_SYNC;
         default: syncMode = DCR_CLOCK_SYNC;
      endcase
      // pin ignored when disabled or in free run
      qualified      = fsyncEn && (syncMode != DCR_FREE_RUN);
      fsyncPrevN_d   = fsyncSyncN;
      frameSyncPulse = qualified && fsyncPrevN_q && !fsyncSyncN;
   end

   // edge history register
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         fsyncPrevN_q <= 1'b1;
      else
         fsyncPrevN_q <= fsyncPrevN_d;
   end

   ignore_free_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (syncMode == DCR_FREE_RUN) |-> !frameSyncPulse) else $error("frame sync acted in free run");
   ignore_disabled_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !fsyncEn |-> !frameSyncPulse) else $error("frame sync acted while disabled");
endmodule // dcr_sync_decode
`default_nettype wire

// ---- logic/dcr_palette.sv ----
`timescale 1ns/1ps
`default_nettype none
// eight-entry colour palette, registered read
module dcr_palette
   import dcr_pkg::*;
#(
   parameter logic [PAL_N*PIX_W-1:0] PALETTE = PALETTE_DEFAULT
)(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // lookup
   input  wire logic [2:0]        sel,
   output logic      [PIX_W-1:0]  color
);
   logic [PIX_W-1:0] color_d;   // looked-up colour

   // pick entry by code
   always_comb
   begin
      color_d = PALETTE[sel*PIX_W +: PIX_W];
   end

   // registered read data
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         color <= '0;
      else
         color <= color_d;
   end
endmodule // dcr_palette
`default_nettype wire

// ---- logic/dcr_display_control.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - timing run off: all display pins and overlay indicators zero
// - output run off clamps pins, ignores polarity
// - output run and timing run both on: pins toggle normally
// - line/frame selects decode four sync modes
// - frame sync enable gates the pin
// - free run ignores frame sync pin
// - overlay one enable gates its active
// - overlay two enable gates its active
// - force backdrop replaces zoom output
// - overlays stay on top of backdrop
// - three-bit code picks eight palette colours
module dcr_display_control
   import dcr_pkg::*;
#(
   parameter logic [PAL_N*PIX_W-1:0] PALETTE = PALETTE_DEFAULT
)(
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_b,
   // register port
   input  wire logic [dcr_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [dcr_pkg::DATA_W-1:0] regWdata,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   output logic      [dcr_pkg::DATA_W-1:0] regRdata,
   // generated timing and pixels from the core
   input  wire logic                    genHsync,
   input  wire logic                    genVsync,
   input  wire logic                    genDataValid,
   input  wire logic                    genPixelClk,
   input  wire logic                    genHalfRateClk,
   input  wire logic [dcr_pkg::PIX_W-1:0] zoomPixel,
   input  wire logic                    ovlOneWindow,
   input  wire logic                    ovlTwoWindow,
   input  wire logic                    ovlPixelValid,
   input  wire logic [dcr_pkg::PIX_W-1:0] ovlPixel,
   // polarity controls from neighbouring register
   input  wire logic                    invHsync,
   input  wire logic                    invVsync,
   input  wire logic                    invDataValid,
   // external frame sync pin, active low
   input  wire logic                    frame_sync_in_n,
   // to the timing generator
   output logic                         timingEnable,
   output dcr_pkg::dcr_sync_mode_t      syncMode,
   output logic                         frameSyncPulse,
   // display pins
   output logic                         disp_hsync,
   output logic                         disp_vsync,
   output logic                         disp_data_valid,
   output logic                         disp_pixel_clk,
   output logic                         disp_half_rate_clk,
   output logic      [dcr_pkg::PIX_W-1:0] dispData,
   output logic                         overlay_one_active,
   output logic                         overlay_two_active
);
   dcr_ctrl_if ctl ();

   logic [CTRL_W-1:0] display_control_q;   // the control register
   logic [CTRL_W-1:0] display_control_d;
   logic [DATA_W-1:0] regRdata_d;          // read mux
   logic              fsyncMeta_q;         // pin sync stage one
   logic              fsyncSyncN_q;        // pin sync stage two
   logic [PIX_W-1:0]  backColor;           // palette colour
   logic              ovlOneShow;          // region one pixel live
   logic              ovlTwoShow;          // region two pixel live
   logic              live;                // both run bits set
   logic [PIX_W-1:0]  pix_d;               // next pixel out
   // next values of the registered pins
   logic              hs_d;
   logic              vs_d;
   logic              dv_d;
   logic              pc_d;
   logic              hc_d;
   logic              oa1_d;
   logic              oa2_d;

   // field decoding used for the one-bit carrier fields and the sync decode inputs
   function automatic logic fieldBit(input logic [CTRL_W-1:0] r, input int pos);
      fieldBit = r[pos];
   endfunction

   // register write and read decode
   always_comb
   begin
      display_control_d = display_control_q;
      regRdata_d        = '0;
      // writes land only at the control offset, status is read-only
      if (regWr && regAddr == DISPLAY_CONTROL_OFS)
         display_control_d = regWdata[CTRL_W-1:0];
      if (regRd)
      begin
         case (regAddr)
            DISPLAY_CONTROL_OFS: regRdata_d = {{(DATA_W-CTRL_W){1'b0}}, display_control_q};
            STATUS_OFS:          regRdata_d = {{(DATA_W-8){1'b0}}, 2'b00, overlay_two_active,
                                               overlay_one_active, syncMode};
            default:             regRdata_d = '0;   // unmapped reads zero
         endcase
      end
   end

   // register state and read data
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         display_control_q <= CTRL_RESET;
         regRdata          <= '0;
      end
      else
      begin
         display_control_q <= display_control_d;
         regRdata          <= regRdata_d;
      end
   end

   // two-stage synchroniser for the frame sync pin
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fsyncMeta_q  <= 1'b1;
         fsyncSyncN_q <= 1'b1;
      end
      else
      begin
         fsyncMeta_q  <= frame_sync_in_n;
         fsyncSyncN_q <= fsyncMeta_q;
      end
   end

   // fields onto the internal carrier
   assign ctl.timingRun = fieldBit(display_control_q, TIMING_GEN_RUN_BIT);
   assign ctl.outputRun = fieldBit(display_control_q, OUTPUT_RUN_BIT);
   assign ctl.ovlOneEn  = fieldBit(display_control_q, OVL_ONE_EN_BIT);
   assign ctl.ovlTwoEn  = fieldBit(display_control_q, OVL_TWO_EN_BIT);
   assign ctl.forceBack = fieldBit(display_control_q, FORCE_BACKDROP_BIT);
   assign ctl.backSel   = display_control_q[BACKDROP_SEL_LSB +: BACKDROP_SEL_W];

   // sync mode and frame sync qualification
   dcr_sync_decode u_sync (
      .core_clk       (core_clk),
      .rst_b          (rst_b),
      .lineSel        (fieldBit(display_control_q, LINE_SYNC_SELECT_BIT)),
      .frameSel       (fieldBit(display_control_q, FRAME_LOCK_SELECT_BIT)),
      .fsyncEn        (fieldBit(display_control_q, FRAME_SYNC_IN_EN_BIT)),
      .fsyncSyncN     (fsyncSyncN_q),
      .syncMode       (syncMode),
      .frameSyncPulse (frameSyncPulse)
   );

   // backdrop palette lookup
   // select changes reach the pins one cycle after other fields
   dcr_palette #(.PALETTE(PALETTE)) u_pal (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .sel      (ctl.backSel),
      .color    (backColor)
   );

   assign timingEnable = ctl.timingRun;

   // output path: overlay priority, backdrop, clamps
   always_comb
   begin
      live       = ctl.timingRun && ctl.outputRun;
      ovlOneShow = ctl.ovlOneEn && ovlOneWindow;
      ovlTwoShow = ctl.ovlTwoEn && ovlTwoWindow;
      // overlay above backdrop above zoom
      if ((ovlOneShow || ovlTwoShow) && ovlPixelValid)
         pix_d = ovlPixel;
      else if (ctl.forceBack)
         pix_d = backColor;
      else
         pix_d = zoomPixel;
      // polarity applied here, the clamp below overrides it
      hs_d  = genHsync ^ invHsync;
      vs_d  = genVsync ^ invVsync;
      dv_d  = genDataValid ^ invDataValid;
      pc_d  = genPixelClk;
      hc_d  = genHalfRateClk;
      // region indicators follow timing run, not output run
      oa1_d = ctl.timingRun && ovlOneShow;
      oa2_d = ctl.timingRun && ovlTwoShow;
      if (!live)
      begin
         // static zero, polarity ignored
         pix_d = '0;
         hs_d  = 1'b0;
         vs_d  = 1'b0;
         dv_d  = 1'b0;
         pc_d  = 1'b0;
         hc_d  = 1'b0;
      end
      // otherwise pins follow generated values
   end

   // registered display pins
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dispData           <= '0;
         disp_hsync         <= 1'b0;
         disp_vsync         <= 1'b0;
         disp_data_valid    <= 1'b0;
         disp_pixel_clk     <= 1'b0;
         disp_half_rate_clk <= 1'b0;
         overlay_one_active <= 1'b0;
         overlay_two_active <= 1'b0;
      end
      else
      begin
         dispData           <= pix_d;
         disp_hsync         <= hs_d;
         disp_vsync         <= vs_d;
         disp_data_valid    <= dv_d;
         disp_pixel_clk     <= pc_d;
         disp_half_rate_clk <= hc_d;
         overlay_one_active <= oa1_d;
         overlay_two_active <= oa2_d;
      end
   end

   // pins held at zero while either run bit is off
   clamp_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(ctl.outputRun) |-> (dispData == '0 && !disp_hsync && !disp_vsync && !disp_data_valid
                                 && !disp_pixel_clk && !disp_half_rate_clk))
      else $error("outputs not clamped");
   timing_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(ctl.timingRun) |-> (dispData == '0 && !disp_hsync && !disp_vsync && !disp_data_valid
                                 && !disp_pixel_clk && !disp_half_rate_clk))
      else $error("outputs live with timing stopped");
   timing_ovl_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(ctl.timingRun) |-> (!overlay_one_active && !overlay_two_active))
      else $error("overlay active with timing stopped");
   // pins follow the generator while running
   run_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(live) |-> disp_hsync == ($past(genHsync) ^ $past(invHsync)))
      else $error("hsync not following generator");
   run_vsync_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(live) |-> disp_vsync == ($past(genVsync) ^ $past(invVsync)))
      else $error("vsync not following generator");
   run_valid_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(live) |-> disp_data_valid == ($past(genDataValid) ^ $past(invDataValid)))
      else $error("data valid not following generator");
   run_clocks_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(live) |-> (disp_pixel_clk == $past(genPixelClk) && disp_half_rate_clk == $past(genHalfRateClk)))
      else $error("display clocks not following generator");
   // overlay region indicators
   ovl_one_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(ctl.ovlOneEn) |-> !overlay_one_active) else $error("region one active while off");
   ovl_one_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(ctl.timingRun) && $past(ovlOneShow)) |-> overlay_one_active)
      else $error("region one window not marked");
   ovl_two_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(ctl.ovlTwoEn) |-> !overlay_two_active) else $error("region two active while off");
   ovl_two_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(ctl.timingRun) && $past(ovlTwoShow)) |-> overlay_two_active)
      else $error("region two window not marked");
   // pixel source priority
   backdrop_force_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(live) && $past(ctl.forceBack) && !$past(ovlOneShow) && !$past(ovlTwoShow))
      |-> dispData == $past(backColor)) else $error("backdrop not forced");
   zoom_pass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(live) && !$past(ctl.forceBack) && !$past(ovlPixelValid)) |-> dispData == $past(zoomPixel))
      else $error("zoom pixel not passed");
   overlay_top_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(live) && $past(ovlOneShow) && $past(ovlPixelValid)) |-> dispData == $past(ovlPixel))
      else $error("overlay lost priority");
   overlay_two_top_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(live) && $past(ovlTwoShow) && $past(ovlPixelValid)) |-> dispData == $past(ovlPixel))
      else $error("region two overlay lost priority");
   // palette word follows the select one cycle later
   backdrop_pick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(rst_b) |-> backColor == PALETTE[$past(ctl.backSel)*PIX_W +: PIX_W]) else $error("backdrop misread");
   // sync mode decode
   mode_decode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (display_control_q[FRAME_LOCK_SELECT_BIT] && !display_control_q[LINE_SYNC_SELECT_BIT])
      |-> syncMode == DCR_FRAME_SYNC) else $error("sync mode misdecoded");
   mode_free_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (display_control_q[FRAME_LOCK_SELECT_BIT] && display_control_q[LINE_SYNC_SELECT_BIT])
      |-> syncMode == DCR_FREE_RUN) else $error("free run misdecoded");
   mode_line_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!display_control_q[FRAME_LOCK_SELECT_BIT] && display_control_q[LINE_SYNC_SELECT_BIT])
      |-> syncMode == DCR_LINE_SYNC) else $error("line sync misdecoded");
   mode_clock_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!display_control_q[FRAME_LOCK_SELECT_BIT] && !display_control_q[LINE_SYNC_SELECT_BIT])
      |-> syncMode == DCR_CLOCK_SYNC) else $error("clock sync misdecoded");
   // register port behaviour
   ctrl_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(regWr) && $past(regAddr) == DISPLAY_CONTROL_OFS) |-> display_control_q == CTRL_W'($past(regWdata)))
      else $error("control write lost");
   ctrl_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(regWr) |-> $stable(display_control_q)) else $error("control changed without a write");
   rd_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !$past(regRd) |-> regRdata == '0) else $error("read data not zero when idle");
endmodule // dcr_display_control
`default_nettype wire

// ---- sim/dcr_display_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the display control register block
module dcr_display_control_tb;
   import dcr_pkg::*;
   // one pending result: kind 0 register read, kind 1 pins
   typedef struct {int cyc; bit kind; logic [31:0] val;} dcr_note_t;
   logic              core_clk = 1'b0;  // 100 MHz
   logic              rst_b = 1'b0;     // async, active low
   logic [ADDR_W-1:0] regAddr = '0;     // register port
   logic [DATA_W-1:0] regWdata = '0;
   logic              regWr = 1'b0;
   logic              regRd = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic [4:0]        gen = '0;         // hsync, vsync, valid, pclk, hclk
   logic [PIX_W-1:0]  zoomPixel = '0;   // zoom filter pixel
   logic [PIX_W-1:0]  ovlPixel = '0;    // overlay pixel
   logic [2:0]        ovl = '0;         // window one, window two, pixel valid
   logic [2:0]        inv = '0;         // hsync, vsync, valid inverts
   logic              fsyncN = 1'b1;    // frame sync pin
   dcr_sync_mode_t    syncMode;
   logic              frameSyncPulse;
   wire  [4:0]        pins;             // hsync, vsync, valid, pclk, hclk
   logic [PIX_W-1:0]  dispData;
   logic              ovlAct1;
   logic              ovlAct2;
   logic              timingOn;         // timing generator enable
   logic [10:0]       ctrl = '0;        // bench copy of display_control
   dcr_note_t         notes[$];         // expected results, oldest first
   int                cyc = 0;          // negedge count
   int                pulses = 0;       // frame sync pulses seen
   int                err_count = 0;
   int                compares = 0;

   // clock
   always #5 core_clk = ~core_clk;

   dcr_display_control dcr_display_control_i (
      .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .genHsync(gen[4]), .genVsync(gen[3]), .genDataValid(gen[2]),
      .genPixelClk(gen[1]), .genHalfRateClk(gen[0]), .zoomPixel(zoomPixel), .ovlOneWindow(ovl[2]),
      .ovlTwoWindow(ovl[1]), .ovlPixelValid(ovl[0]), .ovlPixel(ovlPixel), .invHsync(inv[2]),
      .invVsync(inv[1]), .invDataValid(inv[0]), .frame_sync_in_n(fsyncN), .timingEnable(timingOn),
      .syncMode(syncMode), .frameSyncPulse(frameSyncPulse), .disp_hsync(pins[4]), .disp_vsync(pins[3]),
      .disp_data_valid(pins[2]), .disp_pixel_clk(pins[1]), .disp_half_rate_clk(pins[0]),
      .dispData(dispData), .overlay_one_active(ovlAct1), .overlay_two_active(ovlAct2));

   // mismatch report
   task automatic fail(input string msg);
      err_count++;
      $display("ERROR %0t %s", $time, msg);
   endtask

   // register read data compare
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("read data %h, expected %h", got, exp));
   endtask

   // display pins compare
   task automatic chk_pins(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("pins %h, expected %h", got, exp));
   endtask

   // sync mode compare
   task automatic chk_mode(input dcr_sync_mode_t got, input dcr_sync_mode_t exp);
      compares++;
      if (got !== exp) fail($sformatf("sync mode %h, expected %h", got, exp));
   endtask

   // frame sync pulse count compare
   task automatic chk_count(input int got, input int exp);
      compares++;
      if (got != exp) fail($sformatf("frame sync pulses %0d, expected %0d", got, exp));
   endtask

   // one bus cycle; for a read, d is the expected data
   task automatic reg_op(input bit wr, input logic [7:0] a, input logic [31:0] d);
      regWr <= wr;
      regRd <= !wr;
      regAddr <= a;
      regWdata <= d;
      if (!wr)
         notes.push_back('{cyc, 1'b0, d});
      else if (a == DISPLAY_CONTROL_OFS)
         ctrl = d[10:0];
      @(posedge core_clk);
   endtask

   // strobes low for n cycles
   task automatic idle(input int n);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask

   // random pixel traffic, each cycle's expected pins noted
   task automatic pix_cycles(input int n);
      logic [4:0]  g;
      logic [23:0] z;
      logic [23:0] o;
      logic [2:0]  w;
      logic [2:0]  iv;
      logic        on;
      logic        shown;
      logic [23:0] px;
      for (int i = 0; i < n; i++)
      begin
         g = 5'($urandom);
         z = 24'($urandom);
         o = 24'($urandom);
         w = 3'($urandom);
         iv = 3'($urandom);
         gen <= g;
         zoomPixel <= z;
         ovlPixel <= o;
         ovl <= w;
         inv <= iv;
         on = ctrl[0] & ctrl[1];
         shown = ((ctrl[5] & w[2]) | (ctrl[6] & w[1])) & w[0];
         px = shown ? o : (ctrl[7] ? PALETTE_DEFAULT[ctrl[10:8]*PIX_W +: PIX_W] : z);
         notes.push_back('{cyc, 1'b1, {ctrl[0], on ? g ^ {iv, 2'b00} : 5'h00, on ? px : 24'h000000,
            ctrl[0] & ctrl[5] & w[2], ctrl[0] & ctrl[6] & w[1]}});
         @(posedge core_clk);
      end
   endtask

   // verdict and end of run
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watcher: takes due notes off the queue and compares
   always @(negedge core_clk)
   begin
      while (notes.size() > 0 && notes[0].cyc + 1 == cyc)
      begin
         if (notes[0].kind)
            chk_pins({timingOn, pins, dispData, ovlAct1, ovlAct2}, notes[0].val);
         else
            chk_reg(regRdata, notes[0].val);
         void'(notes.pop_front());
      end
      if (frameSyncPulse === 1'b1)
         pulses++;
      cyc++;
   end

   // watchdog
   initial
   begin
      #(5000 * 10);
      fail("watchdog expired");
      close_out();
   end

   // main sequence
   initial
   begin
      void'($urandom(78));
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      // reset value, upper bits ignored, unmapped address
      reg_op(1'b0, DISPLAY_CONTROL_OFS, 32'h00000000);
      reg_op(1'b1, DISPLAY_CONTROL_OFS, 32'hFFFFFFFF);
      reg_op(1'b0, DISPLAY_CONTROL_OFS, 32'h000007FF);
      reg_op(1'b1, 8'h07, 32'h00000000);
      reg_op(1'b0, 8'h07, 32'h00000000);
      reg_op(1'b0, DISPLAY_CONTROL_OFS, 32'h000007FF);
      idle(2);
      $display("test registers done");
      // pins under random control words, all run bit pairs
      for (int i = 0; i < 40; i++)
      begin
         reg_op(1'b1, DISPLAY_CONTROL_OFS, ($urandom & 32'hFFFFFFFC) | 32'(i % 4));
         idle(2);
         pix_cycles(8);
      end
      $display("test pins done");
      // each sync mode with frame sync input off and on
      for (int m = 0; m < 4; m++)
      begin
         for (int e = 0; e < 2; e++)
         begin
            reg_op(1'b1, DISPLAY_CONTROL_OFS, 32'((e << 4) | (m << 2)));
            idle(2);
            chk_mode(syncMode, dcr_sync_mode_t'(4'h1 << m));
            reg_op(1'b0, STATUS_OFS, 32'h1 << m);
            pulses = 0;
            fsyncN <= 1'b0;
            idle(6);
            fsyncN <= 1'b1;
            idle(6);
            chk_count(pulses, (e == 1 && m != 3) ? 1 : 0);
         end
      end
      $display("test sync modes done");
      idle(3);
      close_out();
   end
endmodule // dcr_display_control_tb
`default_nettype wire
